//--- fhrd_pkg.sv
// package: constants and types for the floppy host register decode
// Summary of operation
// R01: every host register is one byte wide
// R02: accept programmed i/o and dma accesses
// R03: config port at 3f0/3f1 or 370/371, write-only
// R04: blocks disabled at power-up until base set
// R05: config writes only in config state
// R06: one bit picks normal or enhanced floppy mode
// R07: interface and floppy modes chosen independently
// R08: both select bits high gives at-compatible set
// R09: ident low, encoding high gives enhanced-bus set
// R10: both select bits low gives compact-model set
// R11: decode eight base offsets, read/write split
// R12: first status readable except at-compatible mode
// R13: bit 0 step direction, reset zero
// R14: bit 1 write protect low, forced by config
// R15: bit 2 index input active low
// R16: bit 3 head side, reset zero
// R17: bit 4 track zero low, bit 5 step
// R18: bit 6 second drive low, bit 7 interrupt
// R19: writes to read-only offsets are ignored
package fhrd_pkg;
    localparam logic [9:0] CFG_PRIMARY_ADDR   = 10'h3f0;
    localparam logic [9:0] CFG_SECONDARY_ADDR = 10'h370;
    localparam logic [9:0] FDC_BASE_RESET     = 10'h000;
    localparam logic [2:0] OFS_FIRST_STATUS   = 3'h0;
    localparam logic [2:0] OFS_SECOND_STATUS  = 3'h1;
    localparam logic [2:0] OFS_DRIVE_OUTPUT   = 3'h2;
    localparam logic [2:0] OFS_TAPE_SELECT    = 3'h3;
    localparam logic [2:0] OFS_MAIN_STATUS    = 3'h4;
    localparam logic [2:0] OFS_DATA_QUEUE     = 3'h5;
    localparam logic [2:0] OFS_RESERVED       = 3'h6;
    localparam logic [2:0] OFS_DRIVE_INPUT    = 3'h7;
    // configuration register indices, chosen locally
    localparam logic [7:0] CFG_IDX_MODE       = 8'h03;
    localparam logic [7:0] CFG_IDX_BASE       = 8'h20;
    localparam logic [7:0] CFG_IDX_FORCE_WP   = 8'h17;
    localparam logic [7:0] CFG_ENTER_KEY      = 8'h55;
    localparam logic [7:0] CFG_EXIT_KEY       = 8'haa;
    localparam int         MODE_ENH_FLOPPY_BIT = 0;
    localparam int         MODE_IDENT_BIT      = 1;
    localparam int         MODE_ENCODING_BIT   = 2;
    localparam int         FORCE_WP_BIT        = 0;
    localparam logic [7:0] MODE_RESET         = 8'h06;
    localparam logic [7:0] FORCE_WP_RESET     = 8'h00;
    localparam logic [7:0] BYTE_RESET         = 8'h00;

    typedef enum logic [1:0] {
        FHRD_IF_COMPACT  = 2'b00,
        FHRD_IF_ENHANCED = 2'b01,
        FHRD_IF_AT       = 2'b11
    } fhrd_if_mode_type;

    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
        logic       dack;
    } fhrd_bus_type;

    typedef struct packed {
        logic step_dir;
        logic write_prot_n;
        logic index_pulse_n;
        logic head_side;
        logic track_zero_n;
        logic step;
        logic second_drive_present_n;
        logic controller_interrupt_out;
    } fhrd_drive_type;
endpackage

//--- fhrd_cfg.sv
// configuration port: state entry/exit, index and data registers
`timescale 1ns/1ps
module fhrd_cfg
    import fhrd_pkg::*;
(
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         alt_port_i,
    input  wire fhrd_bus_type bus_i,
    output logic              cfg_state_o,
    output logic              cfg_hit_o,
    output logic [7:0]        mode_o,
    output logic [7:0]        force_wp_o,
    output logic [9:0]        base_o,
    output logic              enabled_o
);
    typedef struct packed {
        logic       active;
        logic       enter_seen;
        logic [7:0] index;
        logic [7:0] mode;
        logic [7:0] force_wp;
        logic [9:0] base;
        logic       enabled;
    } fhrd_cfg_state_type;

    fhrd_cfg_state_type state_ff;
    fhrd_cfg_state_type nxt_state;
    logic [9:0]         port;
    logic               hit_idx;
    logic               hit_dat;

    assign port    = alt_port_i ? CFG_SECONDARY_ADDR : CFG_PRIMARY_ADDR; // R03
    assign hit_idx = bus_i.addr == port;
    assign hit_dat = bus_i.addr == (port | 10'h001);
    // write-only: reads are never claimed here
    assign cfg_hit_o = bus_i.wr && !bus_i.dack && (hit_idx || hit_dat); // R03

    always_comb begin
        nxt_state = state_ff;
        if (cfg_hit_o && hit_idx) begin
            if (bus_i.wdata == CFG_EXIT_KEY) begin
                nxt_state.active     = 1'b0;
                nxt_state.enter_seen = 1'b0;
            end else if (bus_i.wdata == CFG_ENTER_KEY) begin
                nxt_state.active     = state_ff.enter_seen;
                nxt_state.enter_seen = 1'b1;
            end else begin
                nxt_state.enter_seen = 1'b0;
                nxt_state.index      = bus_i.wdata;
            end
        end
        if (cfg_hit_o && hit_dat && state_ff.active) begin // R05
            case (state_ff.index)
                CFG_IDX_MODE:     nxt_state.mode = bus_i.wdata;
                CFG_IDX_FORCE_WP: nxt_state.force_wp = bus_i.wdata;
                CFG_IDX_BASE: begin
                    nxt_state.base    = {bus_i.wdata, 2'b00}; // R04
                    nxt_state.enabled = 1'b1; // R04
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '{active: 1'b0, enter_seen: 1'b0, index: BYTE_RESET, mode: MODE_RESET,
                          force_wp: FORCE_WP_RESET, base: FDC_BASE_RESET, enabled: 1'b0}; // R04
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign cfg_state_o = state_ff.active;
    assign mode_o      = state_ff.mode;
    assign force_wp_o  = state_ff.force_wp;
    assign base_o      = state_ff.base;
    assign enabled_o   = state_ff.enabled;
endmodule

//--- fhrd_top.sv
// floppy host register decode: mode select, offset decode, first status
`timescale 1ns/1ps
module fhrd_top
    import fhrd_pkg::*;
(
    input  wire logic           core_clk_i,
    input  wire logic           reset_n_i,
    input  wire logic           alt_port_i,
    input  wire fhrd_bus_type   bus_i,
    input  wire fhrd_drive_type drive_i,
    input  wire logic           write_protect_in_n_i,
    input  wire logic [7:0]     main_status_i,
    input  wire logic [7:0]     data_queue_rd_i,
    input  wire logic [7:0]     drive_input_status_i,
    input  wire logic [7:0]     second_status_i,
    input  wire logic           transfer_request_i,
    input  wire logic           terminal_count_i,
    input  wire logic           density_select_i,
    output logic [7:0]          rdata_o,
    output logic                rdata_oe_o,
    output logic                fdc_write_o,
    output logic [2:0]          fdc_offset_o,
    output logic [7:0]          fdc_wdata_o,
    output logic [7:0]          drive_output_control_o,
    output logic [7:0]          tape_drive_select_o,
    output logic [7:0]          rate_select_o,
    output logic [7:0]          rate_control_o,
    output logic                enhanced_floppy_o,
    output logic [1:0]          interface_mode_o,
    output logic                transfer_request_out_o,
    output logic                transfer_request_oe_o,
    output logic                controller_interrupt_out_o,
    output logic                controller_interrupt_oe_o,
    output logic                terminal_count_in_o,
    output logic                density_select_out_o
);
    typedef struct packed {
        logic [7:0] rdata;
        logic       rdata_oe;
        logic       fdc_write;
        logic [2:0] offset;
        logic [7:0] wdata;
        logic [7:0] drive_output_control;
        logic [7:0] tape_drive_select;
        logic [7:0] rate_select;
        logic [7:0] rate_control;
        logic [7:0] first_status;
    } fhrd_top_state_type;

    fhrd_top_state_type state_ff;
    fhrd_top_state_type nxt_state;
    logic               cfg_state;
    logic               cfg_hit;
    logic [7:0]         mode;
    logic [7:0]         force_wp;
    logic [9:0]         base;
    logic               enabled;
    fhrd_if_mode_type   if_mode;
    logic               fdc_sel;
    logic [2:0]         ofs;
    logic               dma_en;
    logic               wp_n;

    function automatic fhrd_if_mode_type decode_if_mode(input logic [7:0] m);
        case ({m[MODE_IDENT_BIT], m[MODE_ENCODING_BIT]})
            2'b11:   decode_if_mode = FHRD_IF_AT; // R08
            2'b01:   decode_if_mode = FHRD_IF_ENHANCED; // R09
            2'b00:   decode_if_mode = FHRD_IF_COMPACT; // R10
            default: decode_if_mode = FHRD_IF_AT;
        endcase
    endfunction

    fhrd_cfg u_cfg (
        .core_clk_i  (core_clk_i),
        .reset_n_i   (reset_n_i),
        .alt_port_i  (alt_port_i),
        .bus_i       (bus_i),
        .cfg_state_o (cfg_state),
        .cfg_hit_o   (cfg_hit),
        .mode_o      (mode),
        .force_wp_o  (force_wp),
        .base_o      (base),
        .enabled_o   (enabled)
    );

    assign if_mode = decode_if_mode(mode); // R07
    // dma cycles address the data queue directly, so they bypass the base decode
    assign fdc_sel = enabled && (bus_i.dack || (bus_i.addr[9:3] == base[9:3])); // R02 R04 R05
    assign ofs     = bus_i.dack ? OFS_DATA_QUEUE : bus_i.addr[2:0];
    assign dma_en  = state_ff.drive_output_control[3] || (if_mode == FHRD_IF_ENHANCED); // R09
    assign wp_n    = write_protect_in_n_i && !force_wp[FORCE_WP_BIT]; // R14

    always_comb begin
        nxt_state           = state_ff;
        nxt_state.fdc_write = 1'b0;
        nxt_state.rdata_oe  = 1'b0;
        nxt_state.first_status = {drive_i.controller_interrupt_out, drive_i.second_drive_present_n, // R18
                                  drive_i.step, drive_i.track_zero_n, // R17
                                  drive_i.head_side, // R16
                                  drive_i.index_pulse_n, // R15
                                  wp_n, // R14
                                  drive_i.step_dir}; // R13
        if (fdc_sel && bus_i.wr && !cfg_hit) begin
            nxt_state.offset = ofs;
            nxt_state.wdata  = bus_i.wdata; // R01
            case (ofs) // R11
                OFS_DRIVE_OUTPUT: begin
                    nxt_state.drive_output_control = bus_i.wdata;
                    nxt_state.fdc_write            = 1'b1;
                end
                OFS_TAPE_SELECT: begin
                    nxt_state.tape_drive_select = bus_i.wdata; // R06
                    nxt_state.fdc_write         = 1'b1;
                end
                OFS_MAIN_STATUS: begin
                    nxt_state.rate_select = bus_i.wdata;
                    nxt_state.fdc_write   = 1'b1;
                end
                OFS_DATA_QUEUE:  nxt_state.fdc_write = 1'b1;
                OFS_DRIVE_INPUT: begin
                    nxt_state.rate_control = bus_i.wdata;
                    nxt_state.fdc_write    = 1'b1;
                end
                default: ; // R19
            endcase
        end
        if (fdc_sel && bus_i.rd) begin
            nxt_state.offset   = ofs;
            nxt_state.rdata_oe = 1'b1;
            case (ofs) // R11
                OFS_FIRST_STATUS: begin
                    nxt_state.rdata    = state_ff.first_status;
                    nxt_state.rdata_oe = (if_mode != FHRD_IF_AT); // R12
                end
                OFS_SECOND_STATUS: nxt_state.rdata = second_status_i;
                OFS_DRIVE_OUTPUT:  nxt_state.rdata = state_ff.drive_output_control;
                OFS_TAPE_SELECT:   nxt_state.rdata = state_ff.tape_drive_select;
                OFS_MAIN_STATUS:   nxt_state.rdata = main_status_i;
                OFS_DATA_QUEUE:    nxt_state.rdata = data_queue_rd_i;
                OFS_DRIVE_INPUT:   nxt_state.rdata = drive_input_status_i;
                default: begin
                    nxt_state.rdata    = BYTE_RESET;
                    nxt_state.rdata_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '{rdata: BYTE_RESET, rdata_oe: 1'b0, fdc_write: 1'b0, offset: OFS_FIRST_STATUS,
                          wdata: BYTE_RESET, drive_output_control: BYTE_RESET, tape_drive_select: BYTE_RESET,
                          rate_select: BYTE_RESET, rate_control: BYTE_RESET, first_status: BYTE_RESET}; // R13 R16
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign rdata_o                    = state_ff.rdata;
    assign rdata_oe_o                 = state_ff.rdata_oe;
    assign fdc_write_o                = state_ff.fdc_write;
    assign fdc_offset_o               = state_ff.offset;
    assign fdc_wdata_o                = state_ff.wdata;
    assign drive_output_control_o     = state_ff.drive_output_control;
    assign tape_drive_select_o        = state_ff.tape_drive_select;
    assign rate_select_o              = state_ff.rate_select;
    assign rate_control_o             = state_ff.rate_control;
    assign enhanced_floppy_o          = mode[MODE_ENH_FLOPPY_BIT]; // R06
    assign interface_mode_o           = if_mode;
    // pins float in at and compact modes while dma is disabled
    assign transfer_request_out_o     = transfer_request_i;
    assign transfer_request_oe_o      = dma_en; // R08 R09 R10
    assign controller_interrupt_out_o = drive_i.controller_interrupt_out;
    assign controller_interrupt_oe_o  = dma_en; // R08 R09 R10
    assign terminal_count_in_o        = (if_mode == FHRD_IF_ENHANCED) ? !terminal_count_i : terminal_count_i; // R09
    assign density_select_out_o       = (if_mode == FHRD_IF_AT) ? density_select_i : !density_select_i; // R08 R10
endmodule

//--- fhrd_properties.sv
// checker: port properties of the floppy host register decode
`timescale 1ns/1ps
module fhrd_properties
    import fhrd_pkg::*;
(
    input wire logic           core_clk_i,
    input wire logic           reset_n_i,
    input wire fhrd_bus_type   bus_i,
    input wire fhrd_drive_type drive_i,
    input wire logic           terminal_count_i,
    input wire logic           density_select_i,
    input wire logic [7:0]     rdata_o,
    input wire logic           rdata_oe_o,
    input wire logic           fdc_write_o,
    input wire logic [2:0]     fdc_offset_o,
    input wire logic [7:0]     fdc_wdata_o,
    input wire logic [7:0]     drive_output_control_o,
    input wire logic [1:0]     interface_mode_o,
    input wire logic           transfer_request_oe_o,
    input wire logic           controller_interrupt_oe_o,
    input wire logic           terminal_count_in_o,
    input wire logic           density_select_out_o
);
    logic       enh;
    logic [2:0] ofs;
    logic [7:0] pins;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    assign enh = interface_mode_o == FHRD_IF_ENHANCED;
    assign ofs = bus_i.addr[2:0];
    // bit 1 masked: it also follows the force setting
    assign pins = {drive_i.controller_interrupt_out, drive_i.second_drive_present_n, drive_i.step,
                   drive_i.track_zero_n, drive_i.head_side, drive_i.index_pulse_n, 1'b0, drive_i.step_dir};
    a_write_has_cause: assert property (fdc_write_o |-> $past(bus_i.wr) && fdc_wdata_o == $past(bus_i.wdata)
        && !(fdc_offset_o inside {3'h0, 3'h1, 3'h6})) else $error("write pulse without writable write");
    a_ro_write_dropped: assert property (bus_i.wr && !bus_i.dack && ofs inside {3'h0, 3'h1, 3'h6}
        |=> !fdc_write_o) else $error("write to read-only offset taken");
    a_read_has_cause: assert property (rdata_oe_o |-> $past(bus_i.rd)) else $error("data driven without read");
    a_reserved_float: assert property (bus_i.rd && !bus_i.dack && ofs == 3'h6 |=> !rdata_oe_o)
        else $error("reserved offset drove data");
    a_at_status_float: assert property (bus_i.rd && !bus_i.dack && ofs == 3'h0 && interface_mode_o == FHRD_IF_AT
        |=> !rdata_oe_o) else $error("first status driven in at mode");
    a_enh_lines_driven: assert property (enh |-> transfer_request_oe_o && controller_interrupt_oe_o)
        else $error("request lines float in enhanced mode");
    a_dma_enable_gate: assert property (!enh |-> transfer_request_oe_o == drive_output_control_o[3]
        && controller_interrupt_oe_o == drive_output_control_o[3]) else $error("request enable not from dma bit");
    a_line_polarity: assert property (terminal_count_in_o == (enh ^ terminal_count_i)
        && density_select_out_o == ((interface_mode_o != FHRD_IF_AT) ^ density_select_i)) else $error("polarity");
    a_status_bits: assert property (rdata_oe_o && enh && $past(ofs) == 3'h0 && !$past(bus_i.dack)
        |-> (rdata_o & 8'hfd) == $past(pins, 2)) else $error("first status bits wrong");
endmodule
bind fhrd_top fhrd_properties chk_u (.*);

//--- fhrd_host_model.sv
// host model: byte port and dma cycles toward the decode
`timescale 1ns/1ps
module fhrd_host_model
    import fhrd_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_oe_i,
    output fhrd_bus_type    bus_o
);
    logic [7:0] got;
    logic       got_oe;
    initial bus_o = '0;
    // idle cycle after each access, so no line is assigned twice in one step
    task automatic access(input logic [9:0] a, input logic [7:0] d, input logic r, input logic dk);
        @(posedge core_clk_i);
        bus_o <= '{addr: a, wdata: d, rd: r, wr: !r, dack: dk};
        @(posedge core_clk_i);
        // released address and data lines show the inverse, never the stale value; rd, wr and dack drop low
        bus_o <= '{addr: ~a, wdata: ~d, rd: 1'b0, wr: 1'b0, dack: 1'b0};
        #1;
        got = rdata_i;
        got_oe = rdata_oe_i;
    endtask
endmodule

//--- floppy_host_register_decode_test.sv
// testbench: host access sequences against the floppy host register decode
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module floppy_host_register_decode_test
    import fhrd_pkg::*;
();
    localparam logic [9:0] BASE = 10'h1f8;
    localparam logic [9:0] PORT = 10'h370;
    logic           core_clk_i = 1'b0;
    logic           reset_n_i, alt_port_i, write_protect_in_n_i, transfer_request_i, terminal_count_i;
    logic           density_select_i, rdata_oe_o, fdc_write_o, enhanced_floppy_o, transfer_request_out_o;
    logic           transfer_request_oe_o, controller_interrupt_out_o, controller_interrupt_oe_o;
    logic           terminal_count_in_o, density_select_out_o;
    fhrd_bus_type   bus_i;
    fhrd_drive_type drive_i;
    logic [7:0]     main_status_i, data_queue_rd_i, drive_input_status_i, second_status_i, rdata_o, fdc_wdata_o;
    logic [7:0]     drive_output_control_o, tape_drive_select_o, rate_select_o, rate_control_o, mv, ex;
    logic [2:0]     fdc_offset_o;
    logic [1:0]     interface_mode_o;
    logic [7:0]     modes [7] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h01, 8'h05, 8'h07};
    int             failures = 0;
    int             tests_run = 0;
    int             cycles = 0;
    fhrd_top dut_u (.*);
    fhrd_host_model host_u (.core_clk_i, .rdata_i(rdata_o), .rdata_oe_i(rdata_oe_o), .bus_o(bus_i));
    always #4 core_clk_i = ~core_clk_i;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        host_u.access(a, d, 1'b0, 1'b0);
    endtask
    task automatic rd(input logic [9:0] a);
        host_u.access(a, 8'h00, 1'b1, 1'b0);
    endtask
    task automatic cfg(input logic [7:0] i, input logic [7:0] d);
        wr(PORT, i);
        wr(PORT + 10'h001, d);
    endtask
    // a pass costs far less than this; the full run needs about 130 cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        {reset_n_i, write_protect_in_n_i, transfer_request_i, terminal_count_i, density_select_i} = 5'b01000;
        alt_port_i = 1'b1;
        drive_i = '0;
        {second_status_i, main_status_i, data_queue_rd_i, drive_input_status_i} = 32'h11445577;
        repeat (3) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHK("if_mode", FHRD_IF_AT, interface_mode_o)
        `CHK("dma_oe", 1'b0, transfer_request_oe_o)
        rd(BASE + 10'h004);
        `CHK("disabled_oe", 1'b0, host_u.got_oe)
        $display("test reset done");
        wr(10'h3f0, CFG_ENTER_KEY);
        wr(10'h3f0, CFG_ENTER_KEY);
        cfg(CFG_IDX_MODE, 8'h04);
        `CHK("cfg_locked", FHRD_IF_AT, interface_mode_o)
        wr(PORT, CFG_ENTER_KEY);
        wr(PORT, CFG_ENTER_KEY);
        cfg(CFG_IDX_BASE, BASE[9:2]);
        rd(PORT);
        `CHK("cfg_rd_oe", 1'b0, host_u.got_oe)
        $display("test config done");
        for (int o = 0; o < 8; o++) begin
            wr(BASE + 10'(o), 8'hc4 + 8'(o));
            `CHK("wr_pulse", !(o inside {0, 1, 6}), fdc_write_o)
        end
        `CHK("tape_sel", 8'hc7, tape_drive_select_o)
        `CHK("drive_out", 8'hc6, drive_output_control_o)
        for (int o = 1; o < 8; o++) begin
            rd(BASE + 10'(o));
            ex = (o == 2 || o == 3) ? 8'hc4 + 8'(o) : 8'h11 * 8'(o);
            `CHK("rd_oe", o != 6, host_u.got_oe)
            if (o != 6) `CHK("rd_data", ex, host_u.got)
        end
        `CHK("rate_sel", 8'hc8, rate_select_o)
        `CHK("rate_ctl", 8'hcb, rate_control_o)
        host_u.access(10'h000, 8'h00, 1'b1, 1'b1);
        `CHK("dma_rd", 8'h55, host_u.got)
        `CHK("dma_oe", 1'b0, transfer_request_oe_o)
        wr(BASE + 10'h002, 8'h0c);
        `CHK("fdc_write", 1'b1, fdc_write_o)
        `CHK("fdc_ofs", 3'h2, fdc_offset_o)
        `CHK("fdc_wdata", 8'h0c, fdc_wdata_o)
        `CHK("dma_oe", 1'b1, transfer_request_oe_o)
        $display("test decode done");
        foreach (modes[i]) begin
            mv = modes[i];
            cfg(CFG_IDX_MODE, mv);
            {transfer_request_i, terminal_count_i, density_select_i} <= {mv[1], mv[0], mv[2]};
            rd(BASE);
            `CHK("if_mode", {mv[1], mv[1] | mv[2]}, interface_mode_o)
            `CHK("floppy_mode", mv[0], enhanced_floppy_o)
            `CHK("status_oe", ~mv[1], host_u.got_oe)
            `CHK("tc_pol", (mv[2] & ~mv[1]) ^ mv[0], terminal_count_in_o)
            `CHK("dens_pol", ~mv[1] ^ mv[2], density_select_out_o)
            `CHK("drq_out", mv[1], transfer_request_out_o)
        end
        $display("test modes done");
        cfg(CFG_IDX_MODE, 8'h04);
        wr(BASE + 10'h002, 8'h04);
        `CHK("enh_oe", 1'b1, controller_interrupt_oe_o)
        for (int p = 0; p < 2; p++) begin
            drive_i <= fhrd_drive_type'(p ? 8'h5a : 8'ha5);
            write_protect_in_n_i <= p[0];
            rd(BASE);
            ex = {drive_i.controller_interrupt_out, drive_i.second_drive_present_n, drive_i.step, drive_i.track_zero_n,
                  drive_i.head_side, drive_i.index_pulse_n, write_protect_in_n_i, drive_i.step_dir};
            `CHK("first_status", ex, host_u.got)
            `CHK("int_out", drive_i.controller_interrupt_out, controller_interrupt_out_o)
        end
        cfg(CFG_IDX_FORCE_WP, 8'h01);
        rd(BASE);
        `CHK("forced_wp", 1'b0, host_u.got[1])
        wr(PORT, CFG_EXIT_KEY);
        cfg(CFG_IDX_MODE, 8'h06);
        `CHK("cfg_exit", FHRD_IF_ENHANCED, interface_mode_o)
        $display("test status done");
        // second reset mid-run: registers and block enable must fall back
        reset_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        #1;
        `CHK("rst_dor", 8'h00, drive_output_control_o)
        `CHK("rst_mode", FHRD_IF_AT, interface_mode_o)
        rd(BASE + 10'h002);
        `CHK("rst_disabled", 1'b0, host_u.got_oe)
        $display("test second reset done");
        give_verdict();
    end
endmodule
